// *** prsc_top.sv ***
//////////////////////////////////////////////////////////////////////////////
// Purpose: PLL reference type, power and switchover control
// Assumes: References slower than clk_sys_i / 4; host writes shadow fields
// Notes: Shadow fields become active on the update strobe
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
module prsc_top #(
  parameter int CNT_W = prsc_pkg::PRSC_CNT_W
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // Shadow configuration
  input wire logic [prsc_pkg::PRSC_PWR_W-1:0] cfg_pll_pwr_i,
  input wire logic [prsc_pkg::PRSC_CPM_W-1:0] cfg_cp_mode_i,
  input wire logic [prsc_pkg::PRSC_CPI_W-1:0] cfg_cp_current_i,
  input wire logic [prsc_pkg::PRSC_ABP_W-1:0] cfg_antibacklash_i,
  input wire logic cfg_diff_mode_i,
  input wire logic cfg_diff_enable_i,
  input wire logic cfg_primary_pd_i,
  input wire logic cfg_secondary_pd_i,
  input wire logic cfg_sel_secondary_i,
  input wire logic cfg_use_pin_sel_i,
  input wire logic cfg_auto_en_i,
  input wire logic cfg_stay_secondary_i,
  input wire logic cfg_deglitch_dis_i,
  // Update strobe location write
  input wire logic upd_we_i,
  input wire logic [9:0] upd_addr_i,
  input wire logic [7:0] upd_data_i,
  // Pins
  input wire logic ref_select_pin_i,
  input wire logic primary_reference_i,
  input wire logic secondary_reference_i,
  // Outputs
  output logic pll_ref_clk_o,
  output logic pll_on_o,
  output logic diff_buf_pd_o,
  output logic primary_buf_pd_o,
  output logic secondary_buf_pd_o,
  output prsc_pkg::prsc_cp_mode_type cp_mode_o,
  output logic [prsc_pkg::PRSC_CPI_W-1:0] cp_current_o,
  output logic [prsc_pkg::PRSC_ABP_W-1:0] antibacklash_o,
  output logic using_secondary_o,
  output logic primary_missing_o
);
  import prsc_pkg::*;

  initial begin
    if (CNT_W < 3) $error("CNT_W too small for edge counts");
  end

  // Charge pump mode decode
  function automatic prsc_cp_mode_type cp_decode(input logic [PRSC_CPM_W-1:0] f);
    case (f)
      3'h3: cp_decode = PRSC_CP_NORMAL;
      3'h1: cp_decode = PRSC_CP_PUMP_UP;
      3'h2: cp_decode = PRSC_CP_PUMP_DOWN;
      default: cp_decode = PRSC_CP_TRISTATE;
    endcase
  endfunction

  typedef enum logic [1:0] {
    PRSC_ST_PRIMARY,
    PRSC_ST_MISSING,
    PRSC_ST_SECONDARY
  } prsc_state_type;

  //////////////////////////////////////////////////////////////////////////
  // Active configuration
  logic [PRSC_PWR_W-1:0] pwr_r, pwr_nxt;
  logic [PRSC_CPM_W-1:0] cpm_r, cpm_nxt;
  logic [PRSC_CPI_W-1:0] cpi_r, cpi_nxt;
  logic [PRSC_ABP_W-1:0] abp_r, abp_nxt;
  logic diff_r, diff_nxt, diff_en_r, diff_en_nxt;
  logic p_pd_r, p_pd_nxt, s_pd_r, s_pd_nxt;
  logic sel_sec_r, sel_sec_nxt, pin_sel_r, pin_sel_nxt;
  logic auto_r, auto_nxt, stay_r, stay_nxt, degl_dis_r, degl_dis_nxt;
  logic upd_hit;

  assign upd_hit = upd_we_i && (upd_addr_i == PRSC_UPD_ADDR) && (upd_data_i == PRSC_UPD_VAL);

  // Transfer shadow on update
  always_comb begin
    pwr_nxt = pwr_r;
    cpm_nxt = cpm_r;
    cpi_nxt = cpi_r;
    abp_nxt = abp_r;
    diff_nxt = diff_r;
    diff_en_nxt = diff_en_r;
    p_pd_nxt = p_pd_r;
    s_pd_nxt = s_pd_r;
    sel_sec_nxt = sel_sec_r;
    pin_sel_nxt = pin_sel_r;
    auto_nxt = auto_r;
    stay_nxt = stay_r;
    degl_dis_nxt = degl_dis_r;
    if (upd_hit) begin
      pwr_nxt = cfg_pll_pwr_i;
      cpm_nxt = cfg_cp_mode_i;
      cpi_nxt = cfg_cp_current_i;
      abp_nxt = cfg_antibacklash_i;
      diff_nxt = cfg_diff_mode_i;
      diff_en_nxt = cfg_diff_enable_i;
      p_pd_nxt = cfg_primary_pd_i;
      s_pd_nxt = cfg_secondary_pd_i;
      sel_sec_nxt = cfg_sel_secondary_i;
      pin_sel_nxt = cfg_use_pin_sel_i;
      auto_nxt = cfg_auto_en_i;
      stay_nxt = cfg_stay_secondary_i;
      degl_dis_nxt = cfg_deglitch_dis_i;
    end
  end

  // Active configuration registers, inputs off after reset
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      pwr_r <= PRSC_PWR_ASYNC_OFF;
      cpm_r <= '0;
      cpi_r <= PRSC_CPI_RST;
      abp_r <= '0;
      diff_r <= 1'b0;
      diff_en_r <= 1'b0;
      p_pd_r <= 1'b1;
      s_pd_r <= 1'b1;
      sel_sec_r <= 1'b0;
      pin_sel_r <= 1'b0;
      auto_r <= 1'b0;
      stay_r <= 1'b0;
      degl_dis_r <= 1'b0;
    end else begin
      pwr_r <= pwr_nxt;
      cpm_r <= cpm_nxt;
      cpi_r <= cpi_nxt;
      abp_r <= abp_nxt;
      diff_r <= diff_nxt;
      diff_en_r <= diff_en_nxt;
      p_pd_r <= p_pd_nxt;
      s_pd_r <= s_pd_nxt;
      sel_sec_r <= sel_sec_nxt;
      pin_sel_r <= pin_sel_nxt;
      auto_r <= auto_nxt;
      stay_r <= stay_nxt;
      degl_dis_r <= degl_dis_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic prim_s, sec_s, sel_pin_s;

  prsc_sync u_sync_prim (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .async_i(primary_reference_i),
    .sync_o(prim_s)
  );
  prsc_sync u_sync_sec (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .async_i(secondary_reference_i),
    .sync_o(sec_s)
  );
  prsc_sync u_sync_sel (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .async_i(ref_select_pin_i),
    .sync_o(sel_pin_s)
  );

  //////////////////////////////////////////////////////////////////////////
  // Power and buffer control
  logic pll_off;
  assign pll_off = (pwr_r != PRSC_PWR_NORMAL);
  assign pll_on_o = !pll_off;
  assign diff_buf_pd_o = pll_off || !diff_r || !diff_en_r;
  assign primary_buf_pd_o = pll_off || p_pd_r || diff_r;
  assign secondary_buf_pd_o = pll_off || s_pd_r || diff_r;
  assign cp_mode_o = cp_decode(cpm_r);
  assign cp_current_o = cpi_r;
  assign antibacklash_o = abp_r;

  //////////////////////////////////////////////////////////////////////////
  // Switchover state machine
  prsc_state_type st_r, st_nxt;
  logic [CNT_W-1:0] miss_cnt_r, miss_cnt_nxt, ret_cnt_r, ret_cnt_nxt;
  logic [CNT_W-1:0] ret_fall_r, ret_fall_nxt;
  logic prim_d_r, sec_d_r, ctx_r;
  logic prim_rise, prim_edge, sec_rise, sec_fall;
  logic manual_sec, ctx, ctx_chg;
  logic use_sec_r, use_sec_nxt, gate_r, gate_nxt, out_r, out_nxt;

  assign prim_edge = prim_s ^ prim_d_r;
  assign prim_rise = prim_s && !prim_d_r;
  assign sec_rise = sec_s && !sec_d_r;
  assign sec_fall = !sec_s && sec_d_r;
  assign manual_sec = pin_sel_r ? sel_pin_s : sel_sec_r;
  assign ctx = manual_sec;
  assign ctx_chg = (ctx != ctx_r) || upd_hit;

  // Next switchover state
  always_comb begin
    st_nxt = st_r;
    miss_cnt_nxt = miss_cnt_r;
    ret_cnt_nxt = ret_cnt_r;
    ret_fall_nxt = ret_fall_r;
    if (diff_r || !auto_r || ctx_chg) begin
      st_nxt = PRSC_ST_PRIMARY;
      miss_cnt_nxt = '0;
      ret_cnt_nxt = '0;
      ret_fall_nxt = '0;
    end else begin
      case (st_r)
        PRSC_ST_PRIMARY: begin
          if (prim_edge) begin
            miss_cnt_nxt = '0;
          end else if (sec_fall) begin
            miss_cnt_nxt = miss_cnt_r + 1'b1;
            if (miss_cnt_r == CNT_W'(PRSC_MISS_FALLS - 1)) begin
              st_nxt = PRSC_ST_MISSING;
              miss_cnt_nxt = '0;
            end
          end
        end
        PRSC_ST_MISSING: begin
          if (sec_rise) begin
            st_nxt = PRSC_ST_SECONDARY;
          end
        end
        PRSC_ST_SECONDARY: begin
          if (!stay_r) begin
            if (sec_fall) begin
              ret_fall_nxt = ret_fall_r + 1'b1;
              if (ret_fall_r == CNT_W'(PRSC_MISS_FALLS - 1)) begin
                ret_cnt_nxt = '0;
                ret_fall_nxt = '0;
              end
            end
            if (prim_rise) begin
              ret_cnt_nxt = ret_cnt_r + 1'b1;
              ret_fall_nxt = '0;
              if (ret_cnt_r == CNT_W'(PRSC_RETURN_RISES - 1)) begin
                st_nxt = PRSC_ST_PRIMARY;
                ret_cnt_nxt = '0;
              end
            end
          end
        end
        default: st_nxt = PRSC_ST_PRIMARY;
      endcase
    end
  end

  // Selection and deglitch gate
  always_comb begin
    if (diff_r) begin
      use_sec_nxt = 1'b0;
    end else if (auto_r) begin
      use_sec_nxt = (st_nxt == PRSC_ST_SECONDARY);
    end else begin
      use_sec_nxt = manual_sec;
    end
    gate_nxt = gate_r;
    if (use_sec_nxt != use_sec_r) begin
      gate_nxt = !degl_dis_r;
    end else if (gate_r && !(use_sec_r ? sec_s : prim_s)) begin
      gate_nxt = 1'b0;
    end
    if (gate_r) begin
      out_nxt = 1'b0;
    end else begin
      out_nxt = use_sec_r ? sec_s : prim_s;
    end
  end

  // Switchover registers
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st_r <= PRSC_ST_PRIMARY;
      miss_cnt_r <= '0;
      ret_cnt_r <= '0;
      ret_fall_r <= '0;
      prim_d_r <= 1'b0;
      sec_d_r <= 1'b0;
      ctx_r <= 1'b0;
      use_sec_r <= 1'b0;
      gate_r <= 1'b0;
      out_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      miss_cnt_r <= miss_cnt_nxt;
      ret_cnt_r <= ret_cnt_nxt;
      ret_fall_r <= ret_fall_nxt;
      prim_d_r <= prim_s;
      sec_d_r <= sec_s;
      ctx_r <= ctx;
      use_sec_r <= use_sec_nxt;
      gate_r <= gate_nxt;
      out_r <= out_nxt;
    end
  end

  assign pll_ref_clk_o = out_r;
  assign using_secondary_o = use_sec_r;
  assign primary_missing_o = (st_r != PRSC_ST_PRIMARY);
endmodule

// *** prsc_pkg.sv ***
//////////////////////////////////////////////////////////////////////////////
// Purpose: Constants for the PLL reference switchover control block
// Assumes: Single 100 MHz system clock, references sampled as pins
// Notes: Register bit positions kept as named constants
// Contract
// - Antibacklash pulse width comes from a two-bit configuration field.
// - Charge pump mode field selects tristate, normal, pump up or pump down.
// - Charge pump current offers eight steps, nominal maximum 4.8 mA.
// - Reference input type, differential or dual single-ended, is configurable.
// - After reset all reference inputs are disabled until enabled.
// - Differential buffer off when PLL off or differential mode unselected.
// - Each single-ended buffer off when PLL off or its own bit set.
// - Differential mode forces both single-ended buffers off.
// - Reference switching exists only in dual single-ended mode.
// - Manual selection comes from a register bit or the select pin.
// - Auto modes: prefer primary with return, or stay on secondary.
// - Primary missing after two secondary falling edges without primary edge.
// - After missing, secondary drives PLL from next secondary rising edge.
// - Revert bit clear: return after four primary rises without two secondary falls.
// - Revert bit set: no auto return; software uses manual mode instead.
// - Deglitch blocks grossly misaligned rising edges during a switch.
// - Configuration takes effect only after update location written with 0x01.
// - PLL power field: 00 normal, 01 asynchronous power-down.
//////////////////////////////////////////////////////////////////////////////
package prsc_pkg;
  // Register 0x010 field layout
  localparam int PRSC_PWR_LSB = 0;
  localparam int PRSC_PWR_W = 2;
  localparam int PRSC_CPM_LSB = 4;
  localparam int PRSC_CPM_W = 3;
  // Register 0x017 field layout
  localparam int PRSC_ABP_LSB = 0;
  localparam int PRSC_ABP_W = 2;
  // Register 0x01C bit positions
  localparam int PRSC_SEL_REVERT_BIT = 3;
  localparam int PRSC_SEL_AUTO_BIT = 4;
  localparam int PRSC_SEL_DEGL_DIS_BIT = 7;
  // Update strobe location and value
  localparam logic [9:0] PRSC_UPD_ADDR = 10'h232;
  localparam logic [7:0] PRSC_UPD_VAL = 8'h01;
  // Power encodings
  localparam logic [1:0] PRSC_PWR_NORMAL = 2'h0;
  localparam logic [1:0] PRSC_PWR_ASYNC_OFF = 2'h1;
  // Charge pump current
  localparam int PRSC_CPI_W = 3;
  localparam int PRSC_CPI_MAX_UA = 4800;
  localparam logic [2:0] PRSC_CPI_RST = 3'h7;
  // Edge counts
  localparam int PRSC_MISS_FALLS = 2;
  localparam int PRSC_RETURN_RISES = 4;
  localparam int PRSC_CNT_W = 3;
  // Charge pump mode output
  typedef enum logic [1:0] {
    PRSC_CP_TRISTATE,
    PRSC_CP_NORMAL,
    PRSC_CP_PUMP_UP,
    PRSC_CP_PUMP_DOWN
  } prsc_cp_mode_type;
endpackage

// *** prsc_sync.sv ***
//////////////////////////////////////////////////////////////////////////////
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Input is asynchronous to clk_sys_i
// Notes: First stage only feeds the second stage
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
module prsc_sync (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic async_i,
  output logic sync_o
);
  logic s1_r, s2_r, s3_r, out_r;
  logic s1_nxt, s2_nxt, s3_nxt, out_nxt;

  // Shift chain and agreement
  always_comb begin
    s1_nxt = async_i;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
    out_nxt = (s2_r == s3_r) ? s3_r : out_r;
  end

  // Register stage
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      out_r <= 1'b0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
      out_r <= out_nxt;
    end
  end

  assign sync_o = out_r;
endmodule

// *** prsc_ref_model.sv ***
// Purpose: Two redundant reference clock sources
// Assumes: Run inputs come from the bench; CMOS levels, never floating
// Notes: A stopped source holds its level, as a lost clock does
`timescale 1ns/10ps
module prsc_ref_model #(
  parameter int PRI_HALF_NS = 37,
  parameter int SEC_HALF_NS = 53
) (
  input wire logic primary_run_i,
  input wire logic secondary_run_i,
  output logic primary_reference_o,
  output logic secondary_reference_o
);
  //////////////////////////////////////////////////////////////////////////////
  // Primary source, unrelated in phase to the system clock
  initial primary_reference_o = 1'b0;
  always begin
    #(PRI_HALF_NS);
    if (primary_run_i) primary_reference_o = ~primary_reference_o;
  end
  // Secondary source, always present while running
  initial secondary_reference_o = 1'b0;
  always begin
    #(SEC_HALF_NS);
    if (secondary_run_i) secondary_reference_o = ~secondary_reference_o;
  end
endmodule

// *** prsc_top_chk.sv ***
// Purpose: Port assertions for the reference switchover control
// Assumes: One clock, synchronous active-high reset
// Notes: Bound to every instance of the top module
`timescale 1ns/10ps
module prsc_top_chk #(
  parameter int CNT_W = prsc_pkg::PRSC_CNT_W
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic [prsc_pkg::PRSC_PWR_W-1:0] cfg_pll_pwr_i,
  input wire logic [prsc_pkg::PRSC_CPM_W-1:0] cfg_cp_mode_i,
  input wire logic cfg_diff_mode_i,
  input wire logic cfg_sel_secondary_i,
  input wire logic cfg_use_pin_sel_i,
  input wire logic cfg_auto_en_i,
  input wire logic upd_we_i,
  input wire logic [9:0] upd_addr_i,
  input wire logic [7:0] upd_data_i,
  input wire logic pll_on_o,
  input wire logic diff_buf_pd_o,
  input wire logic primary_buf_pd_o,
  input wire logic secondary_buf_pd_o,
  input wire prsc_pkg::prsc_cp_mode_type cp_mode_o,
  input wire logic using_secondary_o
);
  import prsc_pkg::*;
  //////////////////////////////////////////////////////////////////////////////
  // Update strobe decode and mode map
  logic take;
  assign take = upd_we_i && upd_addr_i == PRSC_UPD_ADDR && upd_data_i == PRSC_UPD_VAL;
  function automatic logic [1:0] cpm_map(input logic [2:0] c);
    case (c)
      3'h3: return PRSC_CP_NORMAL;
      3'h1: return PRSC_CP_PUMP_UP;
      3'h2: return PRSC_CP_PUMP_DOWN;
      default: return PRSC_CP_TRISTATE;
    endcase
  endfunction
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  sequence s_take;
    take;
  endsequence
  sequence s_man_sec;
    take && !cfg_diff_mode_i && !cfg_auto_en_i && !cfg_use_pin_sel_i && cfg_sel_secondary_i;
  endsequence
  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  AST_PWR: assert property (s_take |=> pll_on_o == ($past(cfg_pll_pwr_i) == PRSC_PWR_NORMAL))
    else $error("power state differs from update");
  AST_HOLD: assert property (!take |=> $stable(pll_on_o) && $stable(cp_mode_o))
    else $error("active setting changed without update");
  AST_CPM: assert property (s_take |=> cp_mode_o == cpm_map($past(cfg_cp_mode_i)))
    else $error("charge pump mode wrong");
  AST_OFF: assert property (!pll_on_o |-> diff_buf_pd_o && primary_buf_pd_o && secondary_buf_pd_o)
    else $error("buffer on while PLL off");
  AST_DIFF: assert property ((s_take and cfg_diff_mode_i) |=> primary_buf_pd_o && secondary_buf_pd_o)
    else $error("single-ended buffer on in differential mode");
  AST_SEONLY: assert property ((s_take and !cfg_diff_mode_i) |=> diff_buf_pd_o)
    else $error("differential buffer on while unselected");
  AST_RST: assert property ($fell(srst_i) |-> !pll_on_o && diff_buf_pd_o && primary_buf_pd_o && secondary_buf_pd_o)
    else $error("inputs enabled after reset");
  AST_MAN: assert property (s_man_sec |-> ##[1:8] using_secondary_o)
    else $error("manual select ignored");
  AST_DIFFSW: assert property ((s_take and cfg_diff_mode_i) |-> ##[1:8] !using_secondary_o)
    else $error("secondary used in differential mode");
endmodule
bind prsc_top prsc_top_chk #(.CNT_W(CNT_W)) u_prsc_chk (.*);

// *** prsc_top_tb.sv ***
// Purpose: Self-checking bench for the reference switchover control
// Assumes: 100 MHz clock, reference sources from the partner model
// Notes: Driver queues expectations, monitor pops them on results
`timescale 1ns/10ps
module prsc_top_tb;
  import prsc_pkg::*;
  logic clk_sys_i = 1'b0, srst_i = 1'b1, upd_we_i = 1'b0, pri_run = 1'b1, upd_d = 1'b0, sec_last = 1'b0;
  logic [1:0] cfg_pll_pwr_i = 2'h1, cfg_antibacklash_i = 2'h0;
  logic [2:0] cfg_cp_mode_i = 3'h0, cfg_cp_current_i = 3'h7;
  logic cfg_diff_mode_i = 0, cfg_diff_enable_i = 0, cfg_primary_pd_i = 1, cfg_secondary_pd_i = 1;
  logic cfg_sel_secondary_i = 0, cfg_use_pin_sel_i = 0, cfg_auto_en_i = 0, cfg_stay_secondary_i = 0;
  logic cfg_deglitch_dis_i = 0, ref_select_pin_i = 0;
  logic [9:0] upd_addr_i = 10'h0;
  logic [7:0] upd_data_i = 8'h0;
  logic primary_reference_i, secondary_reference_i, pll_ref_clk_o, pll_on_o, diff_buf_pd_o;
  logic primary_buf_pd_o, secondary_buf_pd_o, using_secondary_o, primary_missing_o;
  prsc_cp_mode_type cp_mode_o;
  logic [2:0] cp_current_o;
  logic [1:0] antibacklash_o;
  logic [10:0] cfg_q[$];
  logic sel_q[$];
  int num_errors = 0, n_compared = 0, cycles = 0, seed = 74;
  logic [31:0] r;
  logic [10:0] act_cfg;
  // Source half periods in ns and edge-count window in clock cycles
  localparam int PRI_H = 37;
  localparam int SEC_H = 53;
  localparam int WIN = 212;
  //////////////////////////////////////////////////////////////////////////////
  // Design, reference sources and clock
  prsc_top uut (.*);
  prsc_ref_model #(.PRI_HALF_NS(PRI_H), .SEC_HALF_NS(SEC_H)) u_refs (.primary_run_i(pri_run), .secondary_run_i(1'b1),
    .primary_reference_o(primary_reference_i), .secondary_reference_o(secondary_reference_i));
  always #5 clk_sys_i = ~clk_sys_i;
  //////////////////////////////////////////////////////////////////////////////
  // Checking and closing
  task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("errors=%0d compared=%0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Expected active outputs from the shadow settings
  function automatic logic [10:0] exp_cfg();
    logic on;
    logic [1:0] m;
    on = (cfg_pll_pwr_i == PRSC_PWR_NORMAL);
    case (cfg_cp_mode_i)
      3'h3: m = PRSC_CP_NORMAL;
      3'h1: m = PRSC_CP_PUMP_UP;
      3'h2: m = PRSC_CP_PUMP_DOWN;
      default: m = PRSC_CP_TRISTATE;
    endcase
    return {on, !on | !cfg_diff_mode_i | !cfg_diff_enable_i, !on | cfg_diff_mode_i | cfg_primary_pd_i,
      !on | cfg_diff_mode_i | cfg_secondary_pd_i, m, cfg_cp_current_i, cfg_antibacklash_i};
  endfunction
  // Active outputs gathered for the update check
  assign act_cfg = {pll_on_o, diff_buf_pd_o, primary_buf_pd_o, secondary_buf_pd_o, cp_mode_o, cp_current_o,
    antibacklash_o};
  // Monitor: timeout, update results and reference changes
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles > 20000) begin
      num_errors++;
      test_done();
    end
    upd_d <= upd_we_i && upd_addr_i == PRSC_UPD_ADDR && upd_data_i == PRSC_UPD_VAL;
    if (upd_d) chk(act_cfg, cfg_q.pop_front());
    sec_last <= using_secondary_o;
    if (!srst_i && using_secondary_o !== sec_last)
      chk(11'(using_secondary_o), 11'(sel_q.size() ? sel_q.pop_front() : ~using_secondary_o));
  end
  //////////////////////////////////////////////////////////////////////////////
  // Driver tasks
  task automatic upd(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    upd_we_i <= 1'b1;
    upd_addr_i <= a;
    upd_data_i <= d;
    if (a == PRSC_UPD_ADDR && d == PRSC_UPD_VAL) cfg_q.push_back(exp_cfg());
    @(posedge clk_sys_i);
    upd_we_i <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
  endtask
  task automatic mode(input logic sel, pin, auto, stay, diff);
    @(posedge clk_sys_i);
    {cfg_pll_pwr_i, cfg_primary_pd_i, cfg_secondary_pd_i, cfg_deglitch_dis_i} <= 5'h00;
    {cfg_diff_mode_i, cfg_diff_enable_i} <= {diff, diff};
    {cfg_sel_secondary_i, cfg_use_pin_sel_i, cfg_auto_en_i, cfg_stay_secondary_i} <= {sel, pin, auto, stay};
    upd(PRSC_UPD_ADDR, PRSC_UPD_VAL);
  endtask
  task automatic drive(input logic run, pin);
    @(posedge clk_sys_i);
    pri_run <= run;
    ref_select_pin_i <= pin;
  endtask
  task automatic wait_sel(input logic v, input logic push);
    int n;
    int e;
    logic p;
    if (push) sel_q.push_back(v);
    for (int k = 0; k < 400 && using_secondary_o !== v; k++) @(posedge clk_sys_i);
    repeat (40) @(posedge clk_sys_i);
    // PLL reference must rise at the rate of the selected source
    n = 0;
    p = pll_ref_clk_o;
    repeat (WIN) begin
      @(posedge clk_sys_i);
      if (pll_ref_clk_o === 1'b1 && p === 1'b0) n++;
      p = pll_ref_clk_o;
    end
    e = using_secondary_o ? WIN * 10 / (2 * SEC_H) : (pri_run ? WIN * 10 / (2 * PRI_H) : 0);
    chk(11'(n >= e - 1 && n <= e + 2), 11'h001);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (2) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_sys_i);
      r = $random(seed);
      cfg_cp_mode_i <= i[2:0];
      {cfg_deglitch_dis_i, cfg_secondary_pd_i, cfg_primary_pd_i, cfg_diff_enable_i, cfg_diff_mode_i} <= r[13:9];
      {cfg_antibacklash_i, cfg_cp_current_i, cfg_pll_pwr_i} <= r[6:0];
      upd(10'h233, PRSC_UPD_VAL);
      upd(PRSC_UPD_ADDR, 8'h02);
      upd(PRSC_UPD_ADDR, PRSC_UPD_VAL);
    end
    sel_q.push_back(1'b1);
    mode(1, 0, 0, 0, 0);
    wait_sel(1, 0);
    sel_q.push_back(1'b0);
    mode(0, 1, 0, 0, 0);
    wait_sel(0, 0);
    drive(1, 1);
    wait_sel(1, 1);
    drive(1, 0);
    wait_sel(0, 1);
    mode(1, 0, 0, 0, 1);
    mode(0, 0, 1, 0, 1);
    drive(0, 0);
    wait_sel(1, 0);
    chk(11'(primary_missing_o), 11'h000);
    drive(1, 0);
    mode(0, 0, 1, 0, 0);
    drive(0, 0);
    wait_sel(1, 1);
    chk(11'(primary_missing_o), 11'h001);
    drive(1, 0);
    wait_sel(0, 1);
    chk(11'(primary_missing_o), 11'h000);
    mode(0, 0, 1, 1, 0);
    drive(0, 0);
    wait_sel(1, 1);
    chk(11'(primary_missing_o), 11'h001);
    drive(1, 0);
    repeat (300) @(posedge clk_sys_i);
    sel_q.push_back(1'b0);
    mode(0, 0, 0, 1, 0);
    wait_sel(0, 0);
    chk(11'(sel_q.size()), 11'h000);
    test_done();
  end
endmodule
